// >>> rtl/rstg_top.sv
/*
  reset source collector and reset tree generator with cause status.
  assumes 50 mhz bus clock, power-on detection on rst_i, all other sources
  asynchronous levels, and an open-drain reset pin with external pull-up.
*/
// How it works
// - watchdog timeout causes system reset and sets watchdog cause flag.
// - in shallow stop only the reset pin wakeup may reset.
// - in deep stop any enabled wakeup input may reset.
// - wakeup flags survive system reset until software clears them.
// - with monitor enabled, reference clock loss resets and sets cause flag.
// - stop request unacknowledged for 1025 slow oscillator cycles resets.
// - software request resets chip and core tiers, not power-on, debug or test, and sets software cause flag.
// - core lockup resets the system and sets lockup cause flag.
// - debug mailbox reset request holds system reset while set.
// - core hold bit keeps core in reset after system release.
// - power-on-only reset forces every other reset output.
// - power-on-or-low-voltage reset cascades into lower tiers except early chip reset, which releases once the pin drive starts.
// - chip power-on reset adds deep wakeup, cascades into chip reset.
// - not-deep-wakeup reset covers all but non-pin deep wakeup.
// - early chip reset releases before flash initialisation starts.
// - chip reset releases after flash done and pin high.
// - pin driven low at least 128 clocks from idle and until flash done; not driven on deep wakeup.
// - chip reset waits for pin to read high after release.
// - boundary instructions hold reset and set test cause flag.
// - test port reset touches only test logic, no system reset.
// - debug reset request clears only debug port style registers.
`timescale 1ns/100ps
module rstg_top (
  // clock and power-on reset
  input wire logic clock_i,
  input wire logic rst_i,
  // asynchronous reset sources
  input wire logic lvd_i,
  input wire logic watchdog_cause_flag_timeout_i,
  input wire logic ref_clk_lost_low_i,
  input wire logic ref_clk_lost_high_i,
  input wire logic sw_reset_req_i,
  input wire logic lockup_i,
  input wire logic dbg_sys_reset_req_i,
  input wire logic dbg_core_hold_i,
  input wire logic test_boundary_instr_i,
  input wire logic test_port_reset_n_i,
  input wire logic dbg_reset_req_i,
  // low-power mode and wakeup
  input wire logic [1:0] lp_mode_i,
  input wire logic [15:0] wake_src_i,
  input wire logic wake_pin_i,
  input wire logic stop_req_i,
  input wire logic stop_all_ack_i,
  input wire logic lpo_clk_i,
  // flash
  input wire logic flash_init_done_i,
  // reset pin, open drain
  input wire logic reset_pin_i,
  output logic reset_pin_o,
  output logic reset_pin_oe_o,
  // reset tree
  output logic por_only_rst_o,
  output logic por_not_deep_rst_o,
  output logic chip_por_rst_o,
  output logic chip_not_deep_rst_o,
  output logic early_chip_rst_o,
  output logic chip_rst_o,
  output logic core_rst_o,
  output logic test_port_rst_o,
  output logic dbg_regs_rst_o,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o
);
  // ==========================================
  // synchronisation of sources
  logic lpo_meta_q, lpo_sync_q, lpo_prev_q;
  logic pin_meta_q, pin_sync_q;
  logic trst_meta_q, trst_sync_q;
  logic dbg_meta_q, dbg_sync_q;
  logic hold_meta_q, hold_sync_q;
  logic stop_meta_q, stop_sync_q, ack_meta_q, ack_sync_q;
  logic [1:0] mode_meta_q, mode_sync_q;
  logic [15:0] wake_meta_q, wake_sync_q;
  logic [2:0] ctrl_q;
  logic [15:0] wake_en_q;
  logic [15:0] wake_flags_q;
  logic [7:0] status_a_q, status_b_q;
  logic [rstg_pkg::NSRC:0] src;
  logic sack_timeout;
  rstg_sync_if sif ();

  wire loc_hit = ctrl_q[rstg_pkg::CTRL_RANGE] ? ref_clk_lost_high_i : ref_clk_lost_low_i;
  wire rstg_pkg::rstg_mode_t mode = rstg_pkg::rstg_mode_t'(mode_sync_q);
  // deep-stop wakeup is through an enabled input; shallow stop only via pin
  wire [15:0] wake_live = wake_sync_q & wake_en_q;
  wire deep_wake = (mode == rstg_pkg::RSTG_MODE_DEEP) && (|wake_live);
  wire shallow_wake = (mode == rstg_pkg::RSTG_MODE_SHALLOW) && wake_pin_i;

  assign sif.raw[rstg_pkg::SRC_POR] = 1'b0;
  assign sif.raw[rstg_pkg::SRC_LVD] = lvd_i;
  assign sif.raw[rstg_pkg::SRC_WATCHDOG_CAUSE_FLAG] = watchdog_cause_flag_timeout_i;
  assign sif.raw[rstg_pkg::SRC_WAKE] = deep_wake;
  assign sif.raw[rstg_pkg::SRC_LOC] = ctrl_q[rstg_pkg::CTRL_MON_EN] && loc_hit;
  assign sif.raw[rstg_pkg::SRC_SACK] = sack_timeout;
  assign sif.raw[rstg_pkg::SRC_SW] = sw_reset_req_i;
  assign sif.raw[rstg_pkg::SRC_LOCKUP] = lockup_i;
  assign sif.raw[rstg_pkg::SRC_DBG] = dbg_sys_reset_req_i;
  assign sif.raw[rstg_pkg::SRC_TEST] = test_boundary_instr_i;
  assign sif.raw[rstg_pkg::SRC_PIN] = shallow_wake;

  rstg_sync u_sync (
    .clock_i (clock_i),
    .rst_i (rst_i),
    .bus (sif.snk)
  );
  assign src = sif.sync;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      {lpo_meta_q, lpo_sync_q, lpo_prev_q} <= 3'h0;
      {pin_meta_q, pin_sync_q} <= 2'h0;
      {trst_meta_q, trst_sync_q} <= 2'h0;
      {dbg_meta_q, dbg_sync_q, hold_meta_q, hold_sync_q} <= 4'h0;
      {stop_meta_q, stop_sync_q, ack_meta_q, ack_sync_q} <= 4'h0;
      mode_meta_q <= 2'h0;
      mode_sync_q <= 2'h0;
      wake_meta_q <= 16'h0000;
      wake_sync_q <= 16'h0000;
    end else begin
      lpo_meta_q <= lpo_clk_i;
      lpo_sync_q <= lpo_meta_q;
      lpo_prev_q <= lpo_sync_q;
      pin_meta_q <= reset_pin_i;
      pin_sync_q <= pin_meta_q;
      trst_meta_q <= test_port_reset_n_i;
      trst_sync_q <= trst_meta_q;
      dbg_meta_q <= dbg_reset_req_i;
      dbg_sync_q <= dbg_meta_q;
      hold_meta_q <= dbg_core_hold_i;
      hold_sync_q <= hold_meta_q;
      stop_meta_q <= stop_req_i;
      stop_sync_q <= stop_meta_q;
      ack_meta_q <= stop_all_ack_i;
      ack_sync_q <= ack_meta_q;
      mode_meta_q <= lp_mode_i;
      mode_sync_q <= mode_meta_q;
      wake_meta_q <= wake_src_i;
      wake_sync_q <= wake_meta_q;
    end
  end

  rstg_stop_ack u_sack (
    .clock_i (clock_i),
    .rst_i (rst_i),
    .stop_req_i (stop_sync_q),
    .all_ack_i (ack_sync_q),
    .lpo_tick_i (lpo_sync_q && !lpo_prev_q),
    .timeout_o (sack_timeout)
  );

  // ==========================================
  // pin sequencing
  rstg_pkg::rstg_state_t state_q, state_d;
  logic [rstg_pkg::PIN_CNT_W-1:0] pin_cnt_q, pin_cnt_d;
  logic por_seen_q;
  logic pin_low_q;
  // pin falling low with no drive of ours is an external pin reset
  wire ext_pin = !pin_sync_q && !pin_low_q && !por_seen_q;
  wire any_sys = |src[rstg_pkg::SRC_PIN:rstg_pkg::SRC_LVD];
  wire drive_src = any_sys || ext_pin || por_seen_q;
  wire cnt_done = (pin_cnt_q == rstg_pkg::PIN_CNT_LAST);

  always_comb begin
    state_d = state_q;
    pin_cnt_d = pin_cnt_q;
    unique case (state_q)
      rstg_pkg::RSTG_IDLE: begin
        pin_cnt_d = '0;
        if (drive_src) begin
          state_d = rstg_pkg::RSTG_DRIVE;
        end
      end
      rstg_pkg::RSTG_DRIVE: begin
        if (!cnt_done) begin
          pin_cnt_d = pin_cnt_q + 1'b1;
        end
        // held sources (debug, test) keep the pin low while present
        if (cnt_done && flash_init_done_i && !drive_src) begin
          state_d = rstg_pkg::RSTG_PIN_WAIT;
        end
      end
      rstg_pkg::RSTG_PIN_WAIT: begin
        if (drive_src && pin_sync_q) begin
          state_d = rstg_pkg::RSTG_DRIVE;
        end else if (pin_sync_q) begin
          state_d = rstg_pkg::RSTG_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= rstg_pkg::RSTG_IDLE;
      pin_cnt_q <= '0;
      por_seen_q <= 1'b1;
      pin_low_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pin_cnt_q <= pin_cnt_d;
      if (state_q == rstg_pkg::RSTG_DRIVE) begin
        por_seen_q <= 1'b0;
      end
      pin_low_q <= (state_q != rstg_pkg::RSTG_IDLE);
    end
  end

  // ==========================================
  // reset tree
  logic deep_hold_q;
  logic pnd_hold_q;
  wire in_seq = (state_q != rstg_pkg::RSTG_IDLE);
  wire seq_end = (state_d == rstg_pkg::RSTG_IDLE);
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      deep_hold_q <= 1'b0;
      pnd_hold_q <= 1'b1;
    end else begin
      // a non-pin deep wakeup resets power-on tier but not always-on logic
      if (src[rstg_pkg::SRC_WAKE]) begin
        deep_hold_q <= 1'b1;
      end else if (seq_end) begin
        deep_hold_q <= 1'b0;
      end
      if (src[rstg_pkg::SRC_LVD]) begin
        pnd_hold_q <= 1'b1;
      end else if (seq_end) begin
        pnd_hold_q <= 1'b0;
      end
    end
  end
  assign por_only_rst_o = rst_i;
  assign por_not_deep_rst_o = rst_i || pnd_hold_q || src[rstg_pkg::SRC_LVD];
  assign chip_por_rst_o = por_not_deep_rst_o || deep_hold_q || src[rstg_pkg::SRC_WAKE];
  assign chip_not_deep_rst_o = por_not_deep_rst_o || (in_seq && !deep_hold_q);
  assign chip_rst_o = rst_i || in_seq || drive_src;
  // flash released at once so it can run its initialisation inside the sequence
  assign early_chip_rst_o = rst_i || (state_q == rstg_pkg::RSTG_IDLE && drive_src);
  assign core_rst_o = chip_rst_o || hold_sync_q;
  assign test_port_rst_o = rst_i || !trst_sync_q;
  assign dbg_regs_rst_o = rst_i || dbg_sync_q;
  assign reset_pin_o = 1'b0;
  assign reset_pin_oe_o = rst_i || por_seen_q || (state_q == rstg_pkg::RSTG_DRIVE && !deep_hold_q);

  // ==========================================
  // cause status, captured at sequence start
  wire seq_start = (state_q == rstg_pkg::RSTG_IDLE) && (state_d == rstg_pkg::RSTG_DRIVE);
  logic [7:0] cause_a, cause_b;
  always_comb begin
    cause_a = 8'h00;
    cause_b = 8'h00;
    cause_a[rstg_pkg::STA_POR] = por_seen_q;
    cause_a[rstg_pkg::STA_LVD] = por_seen_q || src[rstg_pkg::SRC_LVD];
    cause_a[rstg_pkg::STA_WATCHDOG_CAUSE_FLAG] = src[rstg_pkg::SRC_WATCHDOG_CAUSE_FLAG];
    cause_a[rstg_pkg::STA_WAKE] = src[rstg_pkg::SRC_WAKE] || src[rstg_pkg::SRC_PIN];
    cause_a[rstg_pkg::STA_LOC] = src[rstg_pkg::SRC_LOC];
    cause_a[rstg_pkg::STA_PIN] = ext_pin;
    cause_b[rstg_pkg::STB_SACK] = src[rstg_pkg::SRC_SACK];
    cause_b[rstg_pkg::STB_SW] = src[rstg_pkg::SRC_SW];
    cause_b[rstg_pkg::STB_LOCKUP] = src[rstg_pkg::SRC_LOCKUP];
    cause_b[rstg_pkg::STB_DBG] = src[rstg_pkg::SRC_DBG];
    cause_b[rstg_pkg::STB_TEST] = src[rstg_pkg::SRC_TEST];
  end

  // ==========================================
  // register port
  wire wr_ctrl = reg_wr_i && (reg_addr_i == rstg_pkg::REG_CTRL);
  wire wr_wflags = reg_wr_i && (reg_addr_i == rstg_pkg::REG_WAKE_FLAGS);
  wire wr_wen = reg_wr_i && (reg_addr_i == rstg_pkg::REG_WAKE_EN);
  wire [15:0] wake_set = (mode == rstg_pkg::RSTG_MODE_DEEP) ? wake_live : 16'h0000;
  wire [15:0] wake_clr = wr_wflags ? reg_wdata_i[15:0] : 16'h0000;
  logic [31:0] rd_mux;
  logic [31:0] rdata_q;
  always_comb begin
    unique case (reg_addr_i)
      rstg_pkg::REG_STATUS_A: rd_mux = {24'h00_0000, status_a_q};
      rstg_pkg::REG_STATUS_B: rd_mux = {24'h00_0000, status_b_q};
      rstg_pkg::REG_CTRL: rd_mux = {29'h0000_0000, ctrl_q};
      rstg_pkg::REG_WAKE_FLAGS: rd_mux = {16'h0000, wake_flags_q};
      rstg_pkg::REG_WAKE_EN: rd_mux = {16'h0000, wake_en_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // flags and enables live on power-on reset only, not on chip reset
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= rstg_pkg::CTRL_RST;
      wake_en_q <= rstg_pkg::WAKE_EN_RST;
      wake_flags_q <= rstg_pkg::WAKE_FLAGS_RST;
      status_a_q <= rstg_pkg::STATUS_RST;
      status_b_q <= rstg_pkg::STATUS_RST;
      rdata_q <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata_i[2:0];
      end
      if (wr_wen) begin
        wake_en_q <= reg_wdata_i[15:0];
      end
      wake_flags_q <= (wake_flags_q & ~wake_clr) | wake_set;
      if (seq_start) begin
        status_a_q <= cause_a;
        status_b_q <= cause_b;
      end
      rdata_q <= reg_rd_i ? rd_mux : 32'h0000_0000;
    end
  end
  assign reg_rdata_o = rdata_q;
endmodule

// >>> common/rstg_pkg.sv
/*
  constants for the reset source collector and reset tree generator.
  assumes a 50 mhz bus clock and a 1 khz low-power oscillator clock input.
*/
package rstg_pkg;
  // ==========================================
  // timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned PIN_DRIVE_MIN_CYC = 128;
  localparam int unsigned STOP_ACK_LPO_CYC = 1025;
  localparam int unsigned PIN_CNT_W = 8;
  localparam int unsigned LPO_CNT_W = 11;
  localparam logic [PIN_CNT_W-1:0] PIN_CNT_LAST = PIN_CNT_W'(PIN_DRIVE_MIN_CYC - 1);
  localparam logic [LPO_CNT_W-1:0] STOP_ACK_LAST = LPO_CNT_W'(STOP_ACK_LPO_CYC);
  // ==========================================
  // source vector positions
  localparam int unsigned NSRC = 10;
  localparam int unsigned SRC_POR = 0;
  localparam int unsigned SRC_LVD = 1;
  localparam int unsigned SRC_WATCHDOG_CAUSE_FLAG = 2;
  localparam int unsigned SRC_WAKE = 3;
  localparam int unsigned SRC_LOC = 4;
  localparam int unsigned SRC_SACK = 5;
  localparam int unsigned SRC_SW = 6;
  localparam int unsigned SRC_LOCKUP = 7;
  localparam int unsigned SRC_DBG = 8;
  localparam int unsigned SRC_TEST = 9;
  localparam int unsigned SRC_PIN = 10;
  // ==========================================
  // status field positions
  localparam int unsigned STA_WAKE = 0;
  localparam int unsigned STA_LVD = 1;
  localparam int unsigned STA_LOC = 2;
  localparam int unsigned STA_WATCHDOG_CAUSE_FLAG = 5;
  localparam int unsigned STA_PIN = 6;
  localparam int unsigned STA_POR = 7;
  localparam int unsigned STB_TEST = 0;
  localparam int unsigned STB_LOCKUP = 1;
  localparam int unsigned STB_SW = 2;
  localparam int unsigned STB_DBG = 3;
  localparam int unsigned STB_SACK = 5;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [15:0] WAKE_FLAGS_RST = 16'h0000;
  // ==========================================
  // register map (word index == byte offset / 4)
  localparam logic [3:0] REG_STATUS_A = 4'h0;
  localparam logic [3:0] REG_STATUS_B = 4'h1;
  localparam logic [3:0] REG_CTRL = 4'h2;
  localparam logic [3:0] REG_WAKE_FLAGS = 4'h3;
  localparam logic [3:0] REG_WAKE_EN = 4'h4;
  localparam int unsigned CTRL_MON_EN = 0;
  localparam int unsigned CTRL_RANGE = 1;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [15:0] WAKE_EN_RST = 16'h0000;

  typedef enum logic [1:0] {
    RSTG_MODE_RUN, RSTG_MODE_SHALLOW, RSTG_MODE_DEEP
  } rstg_mode_t;

  typedef enum {
    RSTG_IDLE, RSTG_DRIVE, RSTG_PIN_WAIT
  } rstg_state_t;
endpackage

// >>> common/rstg_sync_if.sv
/*
  bundle of raw asynchronous reset sources and their synchronised copies.
  assumes one clock on both sides of the bundle.
*/
`timescale 1ns/100ps
interface rstg_sync_if;
  logic [rstg_pkg::NSRC:0] raw;
  logic [rstg_pkg::NSRC:0] sync;
  modport src (output raw, input sync);
  modport snk (input raw, output sync);
endinterface

// >>> rtl/rstg_sync.sv
/*
  two-flop synchronisers for every asynchronous reset source.
  assumes sources are levels held for at least two bus clocks.
*/
`timescale 1ns/100ps
module rstg_sync (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // sources
  rstg_sync_if.snk bus
);
  genvar g;
  generate
    for (g = 0; g <= rstg_pkg::NSRC; g++) begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= bus.raw[g];
          sync_q <= meta_q;
        end
      end
      assign bus.sync[g] = sync_q;
    end
  endgenerate
endmodule

// >>> rtl/rstg_stop_ack.sv
/*
  stop-acknowledge timeout: counts low-power oscillator rising edges.
  assumes osc and handshake inputs arrive already synchronised.
*/
`timescale 1ns/100ps
module rstg_stop_ack (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // handshake
  input wire logic stop_req_i,
  input wire logic all_ack_i,
  input wire logic lpo_tick_i,
  // result
  output logic timeout_o
);
  logic [rstg_pkg::LPO_CNT_W-1:0] cnt_q;
  logic [rstg_pkg::LPO_CNT_W-1:0] cnt_d;
  logic timeout_q;
  wire expired = (cnt_q == rstg_pkg::STOP_ACK_LAST);
  wire pending = stop_req_i && !all_ack_i;

  assign cnt_d = !pending ? '0 : (lpo_tick_i && !expired) ? cnt_q + 1'b1 : cnt_q;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      timeout_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      timeout_q <= pending && expired;
    end
  end
  assign timeout_o = timeout_q;
endmodule

// >>> verif/rstg_monitor.sv
/*
  checker for the reset tree generator, watching the top ports only.
  assumes one bus clock and an asynchronous active-high rst_i.
*/
`timescale 1ns/100ps
module rstg_monitor (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // inputs
  input wire logic flash_init_done_i,
  input wire logic reset_pin_i,
  input wire logic test_boundary_instr_i,
  input wire logic dbg_sys_reset_req_i,
  input wire logic dbg_core_hold_i,
  input wire logic test_port_reset_n_i,
  input wire logic dbg_reset_req_i,
  // outputs
  input wire logic reset_pin_oe_o,
  input wire logic por_not_deep_rst_o,
  input wire logic chip_por_rst_o,
  input wire logic chip_not_deep_rst_o,
  input wire logic early_chip_rst_o,
  input wire logic chip_rst_o,
  input wire logic core_rst_o,
  input wire logic test_port_rst_o,
  input wire logic dbg_regs_rst_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // pin drive length, saturating so long holds never wrap
  logic [7:0] oe_cnt_q;
  logic [7:0] oe_cnt_d;
  assign oe_cnt_d = !reset_pin_oe_o ? 8'h00 : (oe_cnt_q == 8'hff) ? oe_cnt_q : oe_cnt_q + 8'h01;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      oe_cnt_q <= 8'h00;
    end else begin
      oe_cnt_q <= oe_cnt_d;
    end
  end
  // ==========================================
  // assertions
  chk_pin_min_hold: assert property ($fell(reset_pin_oe_o) |-> oe_cnt_q >= 8'h80)
    else $error("reset pin released too early");
  chk_pin_flash_wait: assert property (reset_pin_oe_o && !flash_init_done_i |=> reset_pin_oe_o)
    else $error("reset pin released before flash done");
  chk_chip_release: assert property ($fell(chip_rst_o) |-> $past(reset_pin_i, 2) && $past(flash_init_done_i))
    else $error("chip reset released with pin low or flash busy");
  chk_early_first: assert property ($fell(chip_rst_o) |-> !$past(early_chip_rst_o))
    else $error("early chip reset not released first");
  chk_tier_cascade: assert property (por_not_deep_rst_o |-> chip_por_rst_o && chip_not_deep_rst_o && chip_rst_o)
    else $error("upper tier did not cascade");
  chk_chip_cascade: assert property (chip_por_rst_o || chip_not_deep_rst_o |-> chip_rst_o && core_rst_o)
    else $error("chip tier did not cascade");
  chk_test_hold: assert property (test_boundary_instr_i [*4] |-> chip_rst_o)
    else $error("boundary instruction not holding reset");
  chk_dbg_hold: assert property (dbg_sys_reset_req_i [*4] |-> chip_rst_o && reset_pin_oe_o)
    else $error("debug request not holding reset");
  chk_core_hold: assert property ($fell(chip_rst_o) && dbg_core_hold_i |-> core_rst_o)
    else $error("core left reset while held");
  chk_tap_reset: assert property ((!test_port_reset_n_i) [*4] |-> test_port_rst_o)
    else $error("test port reset missing");
  chk_dbg_regs: assert property (dbg_reset_req_i [*4] |-> dbg_regs_rst_o)
    else $error("debug register reset missing");
  cov_chip_release: cover property ($fell(chip_rst_o));
  cov_pin_release: cover property ($fell(reset_pin_oe_o));
  cov_test_hold: cover property (test_boundary_instr_i && chip_rst_o);
endmodule

bind rstg_top rstg_monitor u_mon (.clock_i(clock_i), .rst_i(rst_i), .flash_init_done_i(flash_init_done_i),
  .reset_pin_i(reset_pin_i), .test_boundary_instr_i(test_boundary_instr_i),
  .dbg_sys_reset_req_i(dbg_sys_reset_req_i), .dbg_core_hold_i(dbg_core_hold_i),
  .test_port_reset_n_i(test_port_reset_n_i), .dbg_reset_req_i(dbg_reset_req_i),
  .reset_pin_oe_o(reset_pin_oe_o), .por_not_deep_rst_o(por_not_deep_rst_o), .chip_por_rst_o(chip_por_rst_o),
  .chip_not_deep_rst_o(chip_not_deep_rst_o), .early_chip_rst_o(early_chip_rst_o), .chip_rst_o(chip_rst_o),
  .core_rst_o(core_rst_o), .test_port_rst_o(test_port_rst_o), .dbg_regs_rst_o(dbg_regs_rst_o));

// >>> verif/rstg_pin_model.sv
/*
  reset pin partner: pull-up plus an external circuit that may hold the pin low.
  assumes the design drives the pin only while its output enable is high.
*/
`timescale 1ns/100ps
module rstg_pin_model (
  // design side
  input wire logic pin_drv_i,
  input wire logic pin_oe_i,
  // external circuit
  input wire logic ext_low_i,
  // resolved level
  output logic pin_o
);
  // ==========================================
  // wired level: any low driver wins over the pull-up
  assign pin_o = !ext_low_i && (pin_oe_i ? pin_drv_i : 1'b1);
endmodule

// >>> verif/tb_top.sv
/*
  self-checking bench for the reset tree generator.
  assumes the pin model is the only other party on the reset pin.
*/
`timescale 1ns/100ps
module tb_top;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] src = 8'h00;
  logic lvd_i, watchdog_cause_flag_timeout_i, ref_clk_lost_low_i, ref_clk_lost_high_i, sw_reset_req_i, lockup_i;
  logic dbg_sys_reset_req_i, test_boundary_instr_i, stop_all_ack_i, reset_pin_i, reset_pin_o, reset_pin_oe_o;
  logic dbg_core_hold_i = 1'b0;
  logic test_port_reset_n_i = 1'b1;
  logic dbg_reset_req_i = 1'b0;
  logic [1:0] lp_mode_i = 2'h0;
  logic [15:0] wake_src_i = 16'h0000;
  logic wake_pin_i = 1'b0;
  logic stop_req_i = 1'b0;
  logic lpo_clk_i = 1'b0;
  logic flash_init_done_i = 1'b0;
  logic ext_low = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic por_only_rst_o, por_not_deep_rst_o, chip_por_rst_o, chip_not_deep_rst_o, early_chip_rst_o;
  logic chip_rst_o, core_rst_o, test_port_rst_o, dbg_regs_rst_o;
  int error_cnt = 0;
  int check_count = 0;
  int tb_src[6] = '{0, 1, 2, 3, 4, 7};
  logic [3:0] tb_reg[6] = '{4'h0, 4'h1, 4'h1, 4'h1, 4'h1, 4'h0};
  int tb_bit[6] = '{rstg_pkg::STA_WATCHDOG_CAUSE_FLAG, rstg_pkg::STB_SW, rstg_pkg::STB_LOCKUP, rstg_pkg::STB_DBG,
    rstg_pkg::STB_TEST, rstg_pkg::STA_LVD};
  assign stop_all_ack_i = 1'b0;
  assign {lvd_i, ref_clk_lost_high_i, ref_clk_lost_low_i, test_boundary_instr_i, dbg_sys_reset_req_i, lockup_i,
    sw_reset_req_i, watchdog_cause_flag_timeout_i} = src;
  always #10 clock_i = ~clock_i;
  rstg_top uut (.*);
  rstg_pin_model u_pin (.pin_drv_i(reset_pin_o), .pin_oe_i(reset_pin_oe_o), .ext_low_i(ext_low), .pin_o(reset_pin_i));
  // ==========================================
  // tasks
  function automatic logic [31:0] bitm(input int i);
    return 32'h0000_0001 << i;
  endfunction
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic conclude();
    $display("checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input string msg);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 chk((reg_rdata_o & m) === e, msg);
  endtask
  task automatic idle_chk(input string msg);
    repeat (20) @(posedge clock_i);
    #1 chk(chip_rst_o === 1'b0, msg);
  endtask
  task automatic lpo_pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge clock_i);
      lpo_clk_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      lpo_clk_i <= 1'b0;
    end
    #1;
  endtask
  // b: 0..7 source bit, 8 deep wakeup, 9 other source set by caller, 10 power-on
  task automatic seq(input int b, input int hold);
    int n;
    int oe_n;
    logic nd;
    logic pn;
    logic cp;
    oe_n = 0;
    nd = 1'b0;
    pn = 1'b0;
    cp = 1'b0;
    @(posedge clock_i);
    if (b < 8) src[b] <= 1'b1;
    flash_init_done_i <= 1'b0;
    n = 0;
    while (chip_rst_o !== 1'b1 && n < 20) begin
      @(posedge clock_i);
      #1 n++;
    end
    for (n = 0; n < 200; n++) begin
      @(posedge clock_i);
      if (n == 5) begin
        src <= 8'h00;
        wake_src_i <= 16'h0000;
        wake_pin_i <= 1'b0;
        lp_mode_i <= 2'h0;
        stop_req_i <= 1'b0;
      end
      #1 oe_n += int'(reset_pin_oe_o);
      nd |= chip_not_deep_rst_o;
      pn |= por_not_deep_rst_o;
      cp |= chip_por_rst_o;
    end
    chk(chip_rst_o === 1'b1 && early_chip_rst_o === 1'b0, "early reset not ahead of chip reset");
    ext_low <= (hold > 0);
    flash_init_done_i <= 1'b1;
    repeat (hold) @(posedge clock_i);
    #1 chk(hold == 0 || chip_rst_o === 1'b1, "chip reset left while pin held low");
    ext_low <= 1'b0;
    n = 0;
    while (chip_rst_o !== 1'b0 && n < 200) begin
      @(posedge clock_i);
      #1 n++;
    end
    chk(chip_rst_o === 1'b0, "chip reset stuck");
    if (b < 10) begin
      chk((b == 8) ? oe_n == 0 : oe_n >= 128, "pin drive length");
      chk(nd === (b != 8), "not-deep tier");
      chk(pn === (b == 7), "power-on-not-deep tier");
      chk(cp === (b == 7 || b == 8), "chip power-on tier");
    end
    $display("sequence for source %0d done", b);
  endtask
  // ==========================================
  // tests
  initial begin
    repeat (3) @(posedge clock_i);
    #1 chk({por_only_rst_o, por_not_deep_rst_o, chip_por_rst_o, chip_not_deep_rst_o, early_chip_rst_o, chip_rst_o}
      === 6'h3f, "tree not forced by power-on");
    @(posedge clock_i);
    rst_i <= 1'b0;
    seq(10, 0);
    chk(por_only_rst_o === 1'b0, "power-on-only reset stuck");
    rd(rstg_pkg::REG_STATUS_A, bitm(rstg_pkg::STA_POR), bitm(rstg_pkg::STA_POR), "power-on cause");
    rd(4'hf, 32'hffff_ffff, 32'h0000_0000, "unmapped read");
    for (int i = 0; i < 6; i++) begin
      seq(tb_src[i], (i == 0) ? 30 : 0);
      rd(tb_reg[i], bitm(tb_bit[i]), bitm(tb_bit[i]), "cause flag");
    end
    dbg_core_hold_i <= 1'b1;
    seq(1, 0);
    chk(core_rst_o === 1'b1, "core released despite hold");
    dbg_core_hold_i <= 1'b0;
    repeat (5) @(posedge clock_i);
    #1 chk(core_rst_o === 1'b0, "core hold stuck");
    wr(rstg_pkg::REG_CTRL, 32'h0000_0003);
    src[5] <= 1'b1;
    idle_chk("clock loss reset for other range");
    src[5] <= 1'b0;
    seq(6, 0);
    rd(rstg_pkg::REG_STATUS_A, bitm(rstg_pkg::STA_LOC), bitm(rstg_pkg::STA_LOC), "clock loss cause");
    wr(rstg_pkg::REG_CTRL, 32'h0000_0002);
    src[6] <= 1'b1;
    idle_chk("clock loss reset with monitor off");
    src[6] <= 1'b0;
    wr(rstg_pkg::REG_WAKE_EN, 32'h0000_0001);
    lp_mode_i <= rstg_pkg::RSTG_MODE_SHALLOW;
    wake_src_i <= 16'h0001;
    idle_chk("non-pin wakeup reset in shallow stop");
    wake_pin_i <= 1'b1;
    seq(9, 0);
    wr(rstg_pkg::REG_WAKE_FLAGS, 32'h0000_ffff);
    wr(rstg_pkg::REG_WAKE_EN, 32'h0000_0001);
    lp_mode_i <= rstg_pkg::RSTG_MODE_DEEP;
    wake_src_i <= 16'h0001;
    seq(8, 0);
    rd(rstg_pkg::REG_STATUS_A, bitm(rstg_pkg::STA_WAKE), bitm(rstg_pkg::STA_WAKE), "wakeup cause");
    rd(rstg_pkg::REG_WAKE_FLAGS, 32'h0000_0001, 32'h0000_0001, "wake flag lost over reset");
    wr(rstg_pkg::REG_WAKE_FLAGS, 32'h0000_0001);
    rd(rstg_pkg::REG_WAKE_FLAGS, 32'h0000_0001, 32'h0000_0000, "wake flag not cleared");
    stop_req_i <= 1'b1;
    lpo_pulses(1024);
    chk(chip_rst_o === 1'b0, "stop error too early");
    lpo_pulses(1);
    seq(9, 0);
    rd(rstg_pkg::REG_STATUS_B, bitm(rstg_pkg::STB_SACK), bitm(rstg_pkg::STB_SACK), "stop error cause");
    test_port_reset_n_i <= 1'b0;
    dbg_reset_req_i <= 1'b1;
    idle_chk("system reset from debug or test reset");
    chk(test_port_rst_o === 1'b1 && dbg_regs_rst_o === 1'b1, "debug or test reset missing");
    chk(core_rst_o === 1'b0 && reset_pin_oe_o === 1'b0, "core or pin hit by debug reset");
    test_port_reset_n_i <= 1'b1;
    dbg_reset_req_i <= 1'b0;
    conclude();
  end
  initial begin
    repeat (40000) @(posedge clock_i);
    error_cnt++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    conclude();
  end
endmodule
